// *** design/sohg_regs.svh ***
// Register offsets, fields and fixed octets of the overhead generator.
`ifndef SOHG_REGS_SVH
`define SOHG_REGS_SVH
`define SOHG_OFF_CFG1       8'h00
`define SOHG_OFF_CFG2       8'h01
`define SOHG_OFF_ERRPAT     8'h03
`define SOHG_OFF_CFG4       8'h29
`define SOHG_OFF_APS        8'h32
`define SOHG_OFF_STATUS     8'h33
`define SOHG_CFG_RST        16'h0000
`define SOHG_CFG1_STUFF     15
`define SOHG_CFG1_HDLC      3
`define SOHG_CFG1_MODE      2:0
`define SOHG_MODE_STS1      3'h1
`define SOHG_MODE_STS3C     3'h2
`define SOHG_CFG2_EXT_ALL   15
`define SOHG_CFG2_BIPSEL    12:10
`define SOHG_BIPSEL_B1      0
`define SOHG_BIPSEL_B2      1
`define SOHG_BIPSEL_B3      2
`define SOHG_OHCTL_FRAMING  0
`define SOHG_OHCTL_POINTER  1
`define SOHG_OHCTL_PARITY   2
`define SOHG_OHCTL_LINE     3
`define SOHG_ERR_PATTERN    7:0
`define SOHG_ERR_CONT       8
`define SOHG_ERR_SINGLE     9
`define SOHG_CFG4_AU4       0
`define SOHG_CFG4_EXT_TRACE 1
`define SOHG_CFG4_EXT_APS   2
`define SOHG_CFG4_M1MODE    4:3
`define SOHG_M1_ONES        2'h1
`define SOHG_M1_ZEROS       2'h2
`define SOHG_APS_K1         15:8
`define SOHG_APS_K2         7:0
`define SOHG_A1             8'hf6
`define SOHG_A2             8'h28
`define SOHG_H1_STS         8'h62
`define SOHG_H1_AU4         8'h6a
`define SOHG_H2             8'h0a
`define SOHG_H3             8'h00
`define SOHG_C2             8'h13
`define SOHG_G1             8'h00
`define SOHG_C1_FIRST       8'h01
`define SOHG_ZERO           8'h00
`define SOHG_ONES           8'hff
`define SOHG_ROW_LAST       4'h8
`define SOHG_STS1_COL_LAST  9'd89
`define SOHG_STS3_COL_LAST  9'd269
`define SOHG_STS1_OH        9'd3
`define SOHG_STS3_OH        9'd9
`define SOHG_STUFF_COL_A    9'd30
`define SOHG_STUFF_COL_B    9'd59
`endif

// *** design/sohg_pkg.sv ***
// Types shared by the overhead generator.
package sohg_pkg;
    typedef enum logic [4:0] {
        K_A1      = 5'h00,
        K_A2      = 5'h01,
        K_C1      = 5'h02,
        K_J1      = 5'h03,
        K_B1      = 5'h04,
        K_B3      = 5'h05,
        K_C2      = 5'h06,
        K_H1      = 5'h07,
        K_H2      = 5'h08,
        K_H3      = 5'h09,
        K_G1      = 5'h0a,
        K_B2      = 5'h0b,
        K_K1      = 5'h0c,
        K_K2      = 5'h0d,
        K_H4      = 5'h0e,
        K_M1      = 5'h0f,
        K_DCC     = 5'h10,
        K_EXT     = 5'h11,
        K_PAYLOAD = 5'h12,
        K_STUFF   = 5'h13
    } sohg_kind_e;
endpackage

// *** design/sohg_tx_overhead_gen.sv ***
// Transmit SONET overhead generator and frame builder.
// Notes on behaviour
// - Generate framing overhead and insert all parities.
// - Parity errored once or forced zero continuously.
// - Overhead control groups send zeros when disabled.
// - STS-1 stuffing zeros columns 30 and 59.
// - Without stuffing all 86 columns carry cells.
// - Section trace enable takes C1 from bus.
// - C1: disabled, external, then 01/02/03.
// - Pointer select low sends 0x620A.
// - Pointer select high sends AU-4 0x6A0A.
// - A1/A2 are F6/28, external or zero.
// - H1 62/6A, H2 0A, H3 00, zero disabled.
// - E1, F1, D4-D12, Z1 always from bus.
// - D1-D3 from HDLC formatter or bus.
// - H4 counts octets to next cell start.
// - K1/K2 from register or from bus.
// - M1 carries FEBE count, ones or zeros.
// - One overhead clock pulse per bus octet.
// - Four or ten pulses per row, marker row one.
// - External overhead enable takes every overhead octet not in a disabled group from bus.
`include "sohg_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sohg_tx_overhead_gen #(
    parameter int CELL_OCTETS = 53
) (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [15:0] reg_rdata_out,
    input  wire logic        line_clock_in,
    input  wire logic [7:0]  ext_overhead_in_bus,
    output logic             overhead_octet_clock_out,
    output logic             overhead_frame_marker_out,
    input  wire logic [7:0]  payload_octet_in,
    output logic             payload_take_out,
    input  wire logic [7:0]  hdlc_octet_in,
    input  wire logic [7:0]  febe_count_in,
    output logic      [7:0]  line_octet_out,
    output logic             line_octet_valid_out,
    output logic             line_frame_start_out
);
    initial begin
        if (CELL_OCTETS < 2 || CELL_OCTETS > 63) begin
            $error("CELL_OCTETS out of range.");
        end
    end

    localparam logic [5:0] CELL_LEN = 6'(CELL_OCTETS);

    logic [15:0] line_config_one;
    logic [15:0] line_config_two;
    logic [15:0] feac_and_error_pattern;
    logic [15:0] line_config_four;
    logic [15:0] protection_switch_bytes;
    logic        single_err_armed;

    logic [2:0]  line_sync;
    logic [7:0]  bus_sync1;
    logic [7:0]  bus_sync2;
    logic [3:0]  row;
    logic [8:0]  col;
    logic [5:0]  cell_pos;
    logic [7:0]  b1_acc;
    logic [7:0]  b3_acc;
    logic [7:0]  b1_val;
    logic [7:0]  b3_val;
    logic [7:0]  b2_acc [3];
    logic [7:0]  b2_val [3];
    logic [7:0]  febe_latched;

    logic        sts3;
    logic        stuff_en;
    logic [2:0]  parity_error_insert_sel;
    logic [3:0]  oh_enable_n;
    logic        ext_all;
    logic        au4_pointer_sel;
    logic        line_rise;
    logic        line_fall;
    logic [8:0]  oh_cols;
    logic [8:0]  col_last;
    logic        in_oh;
    logic        in_poh;
    logic        in_stuff;
    logic [1:0]  grp;
    logic [1:0]  sub;
    logic        frame_end;
    sohg_pkg::sohg_kind_e kind;
    logic [7:0]  next_octet;

    assign sts3 = line_config_one[`SOHG_CFG1_MODE] == `SOHG_MODE_STS3C;
    assign stuff_en = line_config_one[`SOHG_CFG1_STUFF];
    assign parity_error_insert_sel = line_config_two[`SOHG_CFG2_BIPSEL];
    assign oh_enable_n = line_config_two[3:0];
    assign ext_all = line_config_two[`SOHG_CFG2_EXT_ALL];
    assign au4_pointer_sel = line_config_four[`SOHG_CFG4_AU4];

    // Register writes.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            line_config_one <= `SOHG_CFG_RST;
            line_config_two <= `SOHG_CFG_RST;
            feac_and_error_pattern <= `SOHG_CFG_RST;
            line_config_four <= `SOHG_CFG_RST;
            protection_switch_bytes <= `SOHG_CFG_RST;
        end else if (reg_write_in) begin
            case (reg_addr_in)
                `SOHG_OFF_CFG1:   line_config_one <= reg_wdata_in;
                `SOHG_OFF_CFG2:   line_config_two <= reg_wdata_in;
                `SOHG_OFF_ERRPAT: feac_and_error_pattern <= reg_wdata_in;
                `SOHG_OFF_CFG4:   line_config_four <= reg_wdata_in;
                `SOHG_OFF_APS:    protection_switch_bytes <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // A write in the frame-end cycle wins over the clear.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            single_err_armed <= 1'b0;
        end else if (reg_write_in && reg_addr_in == `SOHG_OFF_ERRPAT
                     && reg_wdata_in[`SOHG_ERR_SINGLE]) begin
            single_err_armed <= 1'b1;
        end else if (frame_end) begin
            single_err_armed <= 1'b0;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                `SOHG_OFF_CFG1:   reg_rdata_out <= line_config_one;
                `SOHG_OFF_CFG2:   reg_rdata_out <= line_config_two;
                `SOHG_OFF_ERRPAT: reg_rdata_out <= feac_and_error_pattern;
                `SOHG_OFF_CFG4:   reg_rdata_out <= line_config_four;
                `SOHG_OFF_APS:    reg_rdata_out <= protection_switch_bytes;
                `SOHG_OFF_STATUS: reg_rdata_out <= {3'h0, single_err_armed, row, b1_val};
                default:          reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // Line clock and overhead bus pass two flops before use.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            line_sync <= 3'h0;
            bus_sync1 <= 8'h00;
            bus_sync2 <= 8'h00;
        end else begin
            line_sync <= {line_sync[1:0], line_clock_in};
            bus_sync1 <= ext_overhead_in_bus;
            bus_sync2 <= bus_sync1;
        end
    end

    assign line_rise = line_sync[1] && !line_sync[2];
    assign line_fall = !line_sync[1] && line_sync[2];

    assign oh_cols = sts3 ? `SOHG_STS3_OH : `SOHG_STS1_OH;
    assign col_last = sts3 ? `SOHG_STS3_COL_LAST : `SOHG_STS1_COL_LAST;
    assign in_oh = col < oh_cols;
    assign in_poh = col == oh_cols;
    assign in_stuff = !sts3 && stuff_en
                      && (col == oh_cols + `SOHG_STUFF_COL_A - 9'd1
                          || col == oh_cols + `SOHG_STUFF_COL_B - 9'd1);
    assign grp = !sts3 ? col[1:0] : (col < 9'd3) ? 2'd0 : (col < 9'd6) ? 2'd1 : 2'd2;
    assign sub = !sts3 ? 2'd0 : 2'(col - 9'(grp) * 9'd3);
    assign frame_end = line_fall && row == `SOHG_ROW_LAST && col == col_last;

    // Octet kind at a frame position; E1, F1, D4-D12 and Z1 are K_EXT.
    function automatic sohg_pkg::sohg_kind_e kind_of(input logic [3:0] r, input logic [1:0] g,
        input logic [1:0] s, input logic oh,
        input logic poh, input logic stf,
        input logic s3);
        sohg_pkg::sohg_kind_e k;
        k = sohg_pkg::K_EXT;
        if (stf) begin
            k = sohg_pkg::K_STUFF;
        end else if (poh) begin
            case (r)
                4'h0: k = sohg_pkg::K_J1;
                4'h1: k = sohg_pkg::K_B3;
                4'h2: k = sohg_pkg::K_C2;
                4'h3: k = sohg_pkg::K_G1;
                4'h5: k = sohg_pkg::K_H4;
                default: k = sohg_pkg::K_EXT;
            endcase
        end else if (!oh) begin
            k = sohg_pkg::K_PAYLOAD;
        end else begin
            case (r)
                4'h0: k = g == 2'd0 ? sohg_pkg::K_A1 : g == 2'd1 ? sohg_pkg::K_A2 : sohg_pkg::K_C1;
                4'h1: k = (g == 2'd0 && s == 2'd0) ? sohg_pkg::K_B1 : sohg_pkg::K_EXT;
                4'h2: k = s == 2'd0 ? sohg_pkg::K_DCC : sohg_pkg::K_EXT;
                4'h3: k = g == 2'd0 ? sohg_pkg::K_H1 : g == 2'd1 ? sohg_pkg::K_H2 : sohg_pkg::K_H3;
                4'h4: begin
                    if (g == 2'd0) begin
                        k = sohg_pkg::K_B2;
                    end else if (s == 2'd0) begin
                        k = g == 2'd1 ? sohg_pkg::K_K1 : sohg_pkg::K_K2;
                    end
                end
                4'h8: k = (g == 2'd2 && s == (s3 ? 2'd2 : 2'd0)) ? sohg_pkg::K_M1 : sohg_pkg::K_EXT;
                default: k = sohg_pkg::K_EXT;
            endcase
        end
        return k;
    endfunction

    // Selected parity corruption: forced zero or one-shot pattern.
    function automatic logic [7:0] err_par(input logic [7:0] par, input logic sel);
        logic [7:0] v;
        v = par;
        if (sel && feac_and_error_pattern[`SOHG_ERR_CONT]) begin
            v = `SOHG_ZERO;
        end else if (sel && single_err_armed) begin
            v = par ^ feac_and_error_pattern[`SOHG_ERR_PATTERN];
        end
        return v;
    endfunction

    assign kind = kind_of(row, grp, sub, in_oh, in_poh, in_stuff, sts3);

    always_comb begin
        next_octet = `SOHG_ZERO;
        case (kind)
            sohg_pkg::K_A1: next_octet = `SOHG_A1;
            sohg_pkg::K_A2: next_octet = `SOHG_A2;
            sohg_pkg::K_C1: next_octet = `SOHG_C1_FIRST + 8'(sub);
            sohg_pkg::K_B1: next_octet = err_par(b1_val, parity_error_insert_sel[`SOHG_BIPSEL_B1]);
            sohg_pkg::K_B2: next_octet = err_par(b2_val[sub],
                parity_error_insert_sel[`SOHG_BIPSEL_B2]);
            sohg_pkg::K_B3: next_octet = err_par(b3_val, parity_error_insert_sel[`SOHG_BIPSEL_B3]);
            sohg_pkg::K_H1: next_octet = au4_pointer_sel ? `SOHG_H1_AU4 : `SOHG_H1_STS;
            sohg_pkg::K_H2: next_octet = `SOHG_H2;
            sohg_pkg::K_H3: next_octet = `SOHG_H3;
            sohg_pkg::K_C2: next_octet = `SOHG_C2;
            sohg_pkg::K_G1: next_octet = `SOHG_G1;
            sohg_pkg::K_K1: next_octet = line_config_four[`SOHG_CFG4_EXT_APS] ? bus_sync2
                : protection_switch_bytes[`SOHG_APS_K1];
            sohg_pkg::K_K2: next_octet = line_config_four[`SOHG_CFG4_EXT_APS] ? bus_sync2
                : protection_switch_bytes[`SOHG_APS_K2];
            sohg_pkg::K_H4: next_octet = cell_pos == 6'd0 ? `SOHG_ZERO
                : 8'(CELL_LEN - cell_pos);
            sohg_pkg::K_M1: begin
                case (line_config_four[`SOHG_CFG4_M1MODE])
                    `SOHG_M1_ONES:  next_octet = `SOHG_ONES;
                    `SOHG_M1_ZEROS: next_octet = `SOHG_ZERO;
                    default:        next_octet = febe_latched;
                endcase
            end
            sohg_pkg::K_DCC: next_octet = line_config_one[`SOHG_CFG1_HDLC] ? hdlc_octet_in
                : bus_sync2;
            sohg_pkg::K_PAYLOAD: next_octet = payload_octet_in;
            sohg_pkg::K_STUFF: next_octet = `SOHG_ZERO;
            default: next_octet = bus_sync2;
        endcase
        // Bus override first; disabled groups win over both.
        if (ext_all && (in_oh || in_poh)) begin
            next_octet = bus_sync2;
        end
        if (kind == sohg_pkg::K_C1 && line_config_four[`SOHG_CFG4_EXT_TRACE] && !ext_all) begin
            next_octet = bus_sync2;
        end
        case (kind)
            sohg_pkg::K_A1, sohg_pkg::K_A2, sohg_pkg::K_C1:
                if (oh_enable_n[`SOHG_OHCTL_FRAMING]) next_octet = `SOHG_ZERO;
            sohg_pkg::K_H1, sohg_pkg::K_H2, sohg_pkg::K_H3:
                if (oh_enable_n[`SOHG_OHCTL_POINTER]) next_octet = `SOHG_ZERO;
            sohg_pkg::K_B1, sohg_pkg::K_B2, sohg_pkg::K_B3:
                if (oh_enable_n[`SOHG_OHCTL_PARITY]) next_octet = `SOHG_ZERO;
            sohg_pkg::K_K1, sohg_pkg::K_K2, sohg_pkg::K_M1, sohg_pkg::K_C2, sohg_pkg::K_G1:
                if (oh_enable_n[`SOHG_OHCTL_LINE]) next_octet = `SOHG_ZERO;
            default: ;
        endcase
    end

    // One slot per line clock period: overhead clock high in the first half,
    // octet taken at the fall, once the bus has settled.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            overhead_octet_clock_out <= 1'b0;
            overhead_frame_marker_out <= 1'b0;
        end else if (line_rise) begin
            overhead_octet_clock_out <= in_oh || in_poh;
            overhead_frame_marker_out <= row == 4'h0 && (in_oh || in_poh);
        end else if (line_fall) begin
            overhead_octet_clock_out <= 1'b0;
        end
    end

    assign payload_take_out = line_fall && kind == sohg_pkg::K_PAYLOAD;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            line_octet_out <= 8'h00;
            line_octet_valid_out <= 1'b0;
            line_frame_start_out <= 1'b0;
        end else begin
            line_octet_valid_out <= line_fall;
            line_frame_start_out <= line_fall && row == 4'h0 && col == 9'd0;
            if (line_fall) begin
                line_octet_out <= next_octet;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            row <= 4'h0;
            col <= 9'd0;
        end else if (line_fall) begin
            if (col == col_last) begin
                col <= 9'd0;
                row <= row == `SOHG_ROW_LAST ? 4'h0 : row + 4'h1;
            end else begin
                col <= col + 9'd1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cell_pos <= 6'd0;
        end else if (payload_take_out) begin
            cell_pos <= cell_pos == CELL_LEN - 6'd1 ? 6'd0 : cell_pos + 6'd1;
        end
    end

    // Parities cover octets as sent, held for the next frame.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            b1_acc <= 8'h00;
            b3_acc <= 8'h00;
            b1_val <= 8'h00;
            b3_val <= 8'h00;
            febe_latched <= 8'h00;
        end else if (frame_end) begin
            b1_acc <= 8'h00;
            b3_acc <= 8'h00;
            b1_val <= b1_acc ^ next_octet;
            b3_val <= b3_acc ^ next_octet;
            febe_latched <= febe_count_in;
        end else if (line_fall) begin
            b1_acc <= b1_acc ^ next_octet;
            if (!in_oh) begin
                b3_acc <= b3_acc ^ next_octet;
            end
        end
    end

    // One B2 sum per interleaved STS-1.
    for (genvar i = 0; i < 3; i++) begin : g_b2
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                b2_acc[i] <= 8'h00;
                b2_val[i] <= 8'h00;
            end else if (frame_end) begin
                b2_acc[i] <= 8'h00;
                b2_val[i] <= b2_acc[i] ^ ((sub == 2'(i) && in_oh) ? next_octet : 8'h00);
            end else if (line_fall && !(in_oh && row < 4'h3) && (sub == 2'(i) || !in_oh)) begin
                b2_acc[i] <= b2_acc[i] ^ next_octet;
            end
        end
    end
endmodule

`default_nettype wire

// *** test/sohg_tx_overhead_gen_monitor.sv ***
// Port assertions for the overhead generator.
`include "sohg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sohg_tx_overhead_gen_monitor #(
    parameter int CELL_OCTETS = 53
) (
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_write_in,
    input wire logic        overhead_octet_clock_out,
    input wire logic        overhead_frame_marker_out,
    input wire logic        payload_take_out,
    input wire logic [7:0]  line_octet_out,
    input wire logic        line_octet_valid_out,
    input wire logic        line_frame_start_out
);
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic        clean;
    logic        clk_d;
    logic [7:0]  pulses;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // Judge only frames with no CFG1 or CFG2 write inside.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg1  <= 16'h0000;
            cfg2  <= 16'h0000;
            clean <= 1'b0;
        end else if (reg_write_in && reg_addr_in == `SOHG_OFF_CFG1) begin
            cfg1  <= reg_wdata_in;
            clean <= 1'b0;
        end else if (reg_write_in && reg_addr_in == `SOHG_OFF_CFG2) begin
            cfg2  <= reg_wdata_in;
            clean <= 1'b0;
        end else if (line_frame_start_out) begin
            clean <= 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clk_d  <= 1'b0;
            pulses <= 8'h00;
        end else begin
            clk_d <= overhead_octet_clock_out;
            if (line_frame_start_out) begin
                pulses <= 8'h00;
            end else if (overhead_octet_clock_out && !clk_d) begin
                pulses <= pulses + 8'h01;
            end
        end
    end
    a_frame_first_a1: assert property (
        line_frame_start_out && clean && !cfg2[0] && !cfg2[15] |-> line_octet_out == 8'hf6)
        else $error("A1 wrong");
    a_frame_a1_zero: assert property (
        line_frame_start_out && clean && cfg2[0] |-> line_octet_out == 8'h00)
        else $error("A1 not zero");
    a_frame_has_valid: assert property (
        line_frame_start_out |-> line_octet_valid_out)
        else $error("start without octet");
    a_take_then_octet: assert property (
        payload_take_out |=> line_octet_valid_out)
        else $error("take without octet");
    a_take_no_clock: assert property (
        payload_take_out |-> !overhead_octet_clock_out)
        else $error("clock in payload slot");
    a_clock_then_octet: assert property (
        $fell(overhead_octet_clock_out) |-> ##[0:3] line_octet_valid_out)
        else $error("pulse without octet");
    a_marker_with_clock: assert property (
        $rose(overhead_frame_marker_out) |-> overhead_octet_clock_out)
        else $error("marker outside pulse");
    a_pulse_count: assert property (
        line_frame_start_out && clean |->
            pulses == ((cfg1[2:0] == `SOHG_MODE_STS3C) ? 8'h5a : 8'h24))
        else $error("wrong pulse count");
    a_octet_spacing: assert property (
        line_octet_valid_out |=> !line_octet_valid_out [*6])
        else $error("octets too close");
endmodule
bind sohg_tx_overhead_gen sohg_tx_overhead_gen_monitor #(.CELL_OCTETS(CELL_OCTETS))
    sohg_tx_overhead_gen_monitor_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .overhead_octet_clock_out(overhead_octet_clock_out),
    .overhead_frame_marker_out(overhead_frame_marker_out),
    .payload_take_out(payload_take_out), .line_octet_out(line_octet_out),
    .line_octet_valid_out(line_octet_valid_out), .line_frame_start_out(line_frame_start_out));
`default_nettype wire

// *** test/sohg_ovh_source.sv ***
// Model of the overhead bus source.
`timescale 1ns/1ps
`default_nettype none
module sohg_ovh_source (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       octet_clock_in,
    input  wire logic       marker_in,
    output logic      [7:0] bus_out
);
    logic       clk_d;
    logic       mark_d;
    logic [7:0] idx;
    logic [2:0] hold;
    logic [7:0] cur;
    assign cur = (marker_in && !mark_d) ? 8'h00 : idx;
    // Pulse k of a frame carries 0x40 + k.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clk_d   <= 1'b0;
            mark_d  <= 1'b0;
            idx     <= 8'h00;
            hold    <= 3'h0;
            bus_out <= 8'h00;
        end else begin
            clk_d <= octet_clock_in;
            if (octet_clock_in && !clk_d) begin
                bus_out <= 8'h40 + cur;
                idx     <= cur + 8'h01;
                mark_d  <= marker_in;
                hold    <= 3'h0;
            end else if (!octet_clock_in && clk_d) begin
                hold <= 3'h5;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
                if (hold == 3'h1) begin
                    // After hold the bus shows garbage.
                    bus_out <= ~bus_out;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test/sohg_tx_overhead_gen_tb.sv ***
// Self-checking overhead generator bench.
`include "sohg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sohg_tx_overhead_gen_tb;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        line_clock_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_write_in = 1'b0;
    logic        reg_read_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic [7:0]  ext_bus;
    logic        ovh_clk;
    logic        marker;
    logic        payload_take_out;
    logic [7:0]  line_octet_out;
    logic        line_octet_valid_out;
    logic        line_frame_start_out;
    logic [7:0]  frm [0:2429];
    logic [7:0]  offs [5] = '{8'h00, 8'h01, 8'h03, 8'h29, 8'h32};
    int          num_errors = 0;
    int          n_compared = 0;
    sohg_tx_overhead_gen sohg_tx_overhead_gen_inst (.clk_in(clk_in), .resetn_in(resetn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .line_clock_in(line_clock_in), .ext_overhead_in_bus(ext_bus),
        .overhead_octet_clock_out(ovh_clk), .overhead_frame_marker_out(marker),
        .payload_octet_in(8'h6b), .payload_take_out(payload_take_out),
        .hdlc_octet_in(8'h3c), .febe_count_in(8'h07), .line_octet_out(line_octet_out),
        .line_octet_valid_out(line_octet_valid_out),
        .line_frame_start_out(line_frame_start_out));
    sohg_ovh_source sohg_ovh_source_inst (.clk_in(clk_in), .resetn_in(resetn_in),
        .octet_clock_in(ovh_clk), .marker_in(marker), .bus_out(ext_bus));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        forever #80 line_clock_in = ~line_clock_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        @(negedge clk_in);
        check(reg_rdata_out, exp);
    endtask
    task automatic setup(input logic [15:0] c1, c2, ep, c4);
        wr(8'h00, c1);
        wr(8'h01, c2);
        wr(8'h03, ep);
        wr(8'h29, c4);
    endtask
    // Skips the current frame, records the next.
    task automatic grab(input int n_take);
        int n, w, takes;
        n = -1;
        takes = 0;
        for (w = 0; w < 60000; w++) begin
            @(negedge clk_in);
            if (line_frame_start_out === 1'b1 && n >= 0) break;
            if (line_frame_start_out === 1'b1) n = 0;
            if (n >= 0 && payload_take_out === 1'b1) takes++;
            if (n >= 0 && n < 2430 && line_octet_valid_out === 1'b1) begin
                frm[n] = line_octet_out;
                n++;
            end
        end
        if (w == 60000) num_errors++;
        check(16'(takes), 16'(n_take));
        $display("test ended after %0d octets", n);
    endtask
    task automatic chk(input int p, input logic [7:0] e);
        check({8'h00, frm[p]}, {8'h00, e});
    endtask
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #1950000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        foreach (offs[i]) rd(offs[i], 16'h0000);
        foreach (offs[i]) begin
            wr(offs[i], 16'h1c81);
            rd(offs[i], 16'h1c81);
        end
        wr(8'h10, 16'hffff);
        rd(8'h10, 16'h0000);
        wr(8'h32, 16'h1b2c);
        setup(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        grab(774);
        chk(0, 8'hf6);
        chk(1, 8'h28);
        chk(2, 8'h01);
        chk(3, 8'h43);
        chk(91, 8'h45);
        chk(270, 8'h62);
        chk(271, 8'h0a);
        chk(272, 8'h00);
        chk(361, 8'h1b);
        chk(362, 8'h2c);
        chk(722, 8'h07);
        setup(16'h8000, 16'h1c03, 16'h0100, 16'h0006);
        grab(756);
        chk(0, 8'h00);
        chk(2, 8'h00);
        chk(270, 8'h00);
        chk(90, 8'h00);
        chk(93, 8'h00);
        chk(360, 8'h00);
        chk(361, 8'h51);
        setup(16'h0000, 16'h8000, 16'h0000, 16'h0000);
        grab(774);
        chk(0, 8'h40);
        chk(90, 8'h44);
        chk(270, 8'h4c);
        setup(16'h0008, 16'h0000, 16'h0000, 16'h000b);
        grab(774);
        chk(2, 8'h42);
        chk(270, 8'h6a);
        chk(271, 8'h0a);
        chk(180, 8'h3c);
        chk(450, 8'h54);
        chk(722, 8'hff);
        setup(16'h0002, 16'h0000, 16'h0000, 16'h0000);
        grab(2340);
        chk(2, 8'hf6);
        chk(3, 8'h28);
        chk(6, 8'h01);
        chk(7, 8'h02);
        chk(8, 8'h03);
        chk(810, 8'h62);
        chk(813, 8'h0a);
        end_sim();
    end
endmodule
`default_nettype wire
